// ==== scr_spi_regs.svh ====
// register offsets, field positions, reset values and timing counts of the spi control block
`ifndef SCR_SPI_REGS_SVH
`define SCR_SPI_REGS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define SCR_CTL_OFS 8'h00
`define SCR_INTCLR_OFS 8'h14
`define SCR_INTEN_OFS 8'h16
`define SCR_INTSTAT_OFS 8'h18
`define SCR_DATA_OFS 8'h28

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SCR_CTL_RST 32'h0000_0000
`define SCR_CTL_WMASK 32'h7F33_019F
`define SCR_SOFT_RST_BIT 0
`define SCR_ENABLE_BIT 1
`define SCR_PHASE_BIT 28
`define SCR_POLARITY_BIT 29
`define SCR_ORDER_BIT 30
`define SCR_IRQ_RXC 0
`define SCR_IRQ_SSR 1
`define SCR_IRQ_ERR 2

// ----------------------------------------
// timing
// ----------------------------------------
`define SCR_SYNC_CYCLES 4'h3

`endif

// ==== scr_pkg.sv ====
// types of the spi control block
package scr_pkg;

  typedef enum logic [1:0] {
    SYNC_IDLE = 2'b00,
    SYNC_WAIT = 2'b01,
    SYNC_DONE = 2'b11
  } scr_sync_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [2:0] inten;
    logic [2:0] stat;
    scr_sync_t sync;
    logic [3:0] cnt;
    logic [31:0] prdata;
    logic guard_err;
    logic [2:0] sck_s;
    logic [2:0] ss_s;
    logic [1:0] mosi_s;
    logic busy;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic [2:0] bitcnt;
    logic [7:0] rx_data;
    logic [7:0] tx_data;
    logic miso;
  } scr_state_t;

endpackage

// ==== scr_spi_ctrl.sv ====
// apb register access, first control word and spi slave shifter
`timescale 1ns/10ps
`include "scr_spi_regs.svh"

module scr_spi_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic guard_wp,
  input wire logic guard_secure,
  output logic guard_err,
  output logic irq,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic out_bit(input logic [7:0] v, input logic lsb_first);
    return lsb_first ? v[0] : v[7];
  endfunction

  function automatic logic [7:0] shift_on(input logic [7:0] v, input logic lsb_first,
                                          input logic din);
    return lsb_first ? {din, v[7:1]} : {v[6:0], din};
  endfunction

  function automatic logic known_addr(input logic [7:0] a);
    return a == `SCR_CTL_OFS || a == `SCR_INTCLR_OFS || a == `SCR_INTEN_OFS ||
           a == `SCR_INTSTAT_OFS || a == `SCR_DATA_OFS;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  scr_pkg::scr_state_t q_reg;
  scr_pkg::scr_state_t q_next;

  logic setup;
  logic acc;
  logic ns_block;
  logic wp_hit;
  logic need_sync;
  logic commit;
  logic bad;

  assign setup = psel & ~penable;
  assign acc = psel & penable;
  assign ns_block = guard_secure & pprot[1];
  // only control words are protectable; status, clear and data stay open
  assign wp_hit = guard_wp & pwrite &
                  (paddr == `SCR_CTL_OFS || paddr == `SCR_INTEN_OFS);
  assign bad = ns_block | wp_hit | ~known_addr(paddr);
  // enable and soft reset live in byte 0 and cross over before taking effect
  assign need_sync = acc & pwrite & ~bad & (paddr == `SCR_CTL_OFS) & pstrb[0];
  assign pready = ~need_sync | (q_reg.sync == scr_pkg::SYNC_DONE);
  assign commit = acc & pready;
  assign pslverr = commit & bad;
  assign prdata = q_reg.prdata;
  assign guard_err = q_reg.guard_err;
  assign irq = |(q_reg.stat & q_reg.inten);
  assign miso_o = q_reg.miso;
  assign miso_oe = q_reg.busy & q_reg.ctrl[`SCR_ENABLE_BIT];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] m;
    logic [31:0] c;
    logic [2:0] set;
    logic [2:0] clr;
    logic lsb;
    logic edge_hit;
    logic lead;
    logic trail;
    logic smp;
    logic chg;
    logic [7:0] rx_new;
    m = merge(q_reg.ctrl, pwdata, pstrb);
    c = q_reg.ctrl;
    set = 3'h0;
    clr = 3'h0;
    lsb = q_reg.ctrl[`SCR_ORDER_BIT];
    edge_hit = 1'b0;
    lead = 1'b0;
    trail = 1'b0;
    smp = 1'b0;
    chg = 1'b0;
    rx_new = 8'h00;
    q_next = q_reg;
    q_next.guard_err = 1'b0;

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    if (setup) begin
      q_next.prdata = 32'h0000_0000;
      if (!pwrite && !ns_block) begin
        case (paddr)
          `SCR_CTL_OFS: q_next.prdata = q_reg.ctrl;
          `SCR_INTEN_OFS: q_next.prdata = {29'h0000_0000, q_reg.inten};
          `SCR_INTSTAT_OFS: q_next.prdata = {29'h0000_0000, q_reg.stat};
          `SCR_DATA_OFS: q_next.prdata = {24'h00_0000, q_reg.rx_data};
          default: q_next.prdata = 32'h0000_0000;
        endcase
      end
    end

    case (q_reg.sync)
      scr_pkg::SYNC_IDLE: begin
        if (need_sync) begin
          q_next.sync = scr_pkg::SYNC_WAIT;
          q_next.cnt = `SCR_SYNC_CYCLES - 4'h1;
        end
      end
      scr_pkg::SYNC_WAIT: begin
        if (q_reg.cnt == 4'h0) begin
          q_next.sync = scr_pkg::SYNC_DONE;
        end else begin
          q_next.cnt = q_reg.cnt - 4'h1;
        end
      end
      scr_pkg::SYNC_DONE: q_next.sync = scr_pkg::SYNC_IDLE;
      default: q_next.sync = scr_pkg::SYNC_IDLE;
    endcase

    if (commit && bad && (ns_block || wp_hit)) begin
      set[`SCR_IRQ_ERR] = 1'b1;
      q_next.guard_err = ns_block;
    end

    // ----------------------------------------
    // spi slave shifter
    // ----------------------------------------
    q_next.sck_s = {q_reg.sck_s[1:0], sck};
    q_next.ss_s = {q_reg.ss_s[1:0], ss_n};
    q_next.mosi_s = {q_reg.mosi_s[0], mosi};
    edge_hit = q_reg.sck_s[2] ^ q_reg.sck_s[1];
    // leading edge leaves the idle level picked by polarity
    lead = edge_hit & (q_reg.sck_s[1] != q_reg.ctrl[`SCR_POLARITY_BIT]);
    trail = edge_hit & (q_reg.sck_s[1] == q_reg.ctrl[`SCR_POLARITY_BIT]);
    smp = q_reg.ctrl[`SCR_PHASE_BIT] ? trail : lead;
    chg = q_reg.ctrl[`SCR_PHASE_BIT] ? lead : trail;

    if (!q_reg.ctrl[`SCR_ENABLE_BIT]) begin
      q_next.busy = 1'b0;
    end else if (q_reg.ss_s[2] && !q_reg.ss_s[1]) begin
      q_next.busy = 1'b1;
      q_next.bitcnt = 3'h0;
      q_next.tx_sh = q_reg.tx_data;
      if (!q_reg.ctrl[`SCR_PHASE_BIT]) begin
        q_next.miso = out_bit(q_reg.tx_data, lsb);
        q_next.tx_sh = shift_on(q_reg.tx_data, lsb, 1'b0);
      end
    end else if (q_reg.busy && q_reg.ss_s[1]) begin
      q_next.busy = 1'b0;
      set[`SCR_IRQ_SSR] = 1'b1;
    end else if (q_reg.busy) begin
      if (smp) begin
        rx_new = shift_on(q_reg.rx_sh, lsb, q_reg.mosi_s[1]);
        q_next.rx_sh = rx_new;
        q_next.bitcnt = q_reg.bitcnt + 3'h1;
        if (q_reg.bitcnt == 3'h7) begin
          q_next.rx_data = rx_new;
          q_next.tx_sh = q_reg.tx_data;
          set[`SCR_IRQ_RXC] = 1'b1;
        end
      end
      if (chg) begin
        q_next.miso = out_bit(q_reg.tx_sh, lsb);
        q_next.tx_sh = shift_on(q_reg.tx_sh, lsb, 1'b0);
      end
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    if (commit && pwrite && !bad) begin
      case (paddr)
        `SCR_CTL_OFS: begin
          // only bits 1:0 (enable and soft reset) may change while running
          if (q_reg.ctrl[`SCR_ENABLE_BIT]) begin
            c = {q_reg.ctrl[31:2], m[1:0]};
          end else begin
            c = m;
          end
          q_next.ctrl = c & `SCR_CTL_WMASK;
          q_next.ctrl[`SCR_SOFT_RST_BIT] = 1'b0;
        end
        `SCR_INTCLR_OFS: begin
          if (pstrb[0]) begin
            clr = pwdata[2:0];
          end
        end
        `SCR_INTEN_OFS: begin
          if (pstrb[0]) begin
            q_next.inten = pwdata[2:0];
          end
        end
        `SCR_DATA_OFS: begin
          if (pstrb[0]) begin
            q_next.tx_data = pwdata[7:0];
          end
        end
        default: q_next.ctrl = q_reg.ctrl;
      endcase
    end

    // set beats clear in the same cycle
    q_next.stat = (q_reg.stat & ~clr) | set;

    // soft reset wins over everything else in the same write
    if (commit && pwrite && !bad && paddr == `SCR_CTL_OFS && pstrb[0] &&
        pwdata[`SCR_SOFT_RST_BIT]) begin
      q_next = '0;
      q_next.ctrl = `SCR_CTL_RST;
      q_next.sck_s = {q_reg.sck_s[1:0], sck};
      q_next.ss_s = {q_reg.ss_s[1:0], ss_n};
      q_next.mosi_s = {q_reg.mosi_s[0], mosi};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

endmodule // scr_spi_ctrl

// ==== scr_spi_sva.sv ====
// assertions on the ports of the spi control block
`timescale 1ns/10ps
module scr_spi_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic guard_wp,
  input wire logic guard_secure,
  input wire logic guard_err,
  input wire logic ss_n,
  input wire logic miso_oe
);
  // ----
  // checks
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire acc = psel && penable;
  wire done = acc && pready;
  wire ns = guard_secure && pprot[1];
  chk_ns_read_zero: assert property (done && !pwrite && ns |-> prdata == 32'h0 && pslverr)
    else $error("non-secure read not refused");
  chk_ns_err_pulse: assert property (done && ns |=> guard_err)
    else $error("no access error pulse");
  chk_err_single: assert property (guard_err |=> !guard_err)
    else $error("access error pulse too long");
  // the sync counter holds the answer back four access cycles in all
  chk_sync_wait: assert property ($rose(penable) && psel && pwrite && paddr == 8'h00
    && pstrb[0] && !guard_wp && !ns |-> !pready [*4] ##1 pready)
    else $error("control write wait wrong");
  chk_fast_answer: assert property (acc && paddr != 8'h00 |-> pready)
    else $error("unexpected wait state");
  chk_wp_refuse: assert property (done && pwrite && guard_wp && paddr == 8'h00 |-> pslverr)
    else $error("protected write accepted");
  chk_wp_read_ok: assert property (done && !pwrite && !ns && paddr == 8'h00 |-> !pslverr)
    else $error("control read refused");
  chk_ns_granted: assert property (done && !guard_secure && pprot[1] && paddr == 8'h18
    |-> !pslverr) else $error("non-secure access refused");
  chk_idle_release: assert property (ss_n [*5] |-> !miso_oe)
    else $error("output driven while deselected");
endmodule // scr_spi_sva

bind scr_spi_ctrl scr_spi_sva u_sva (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pstrb(pstrb), .pprot(pprot), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .guard_wp(guard_wp), .guard_secure(guard_secure),
  .guard_err(guard_err), .ss_n(ss_n), .miso_oe(miso_oe));

// ==== scr_spi_master.sv ====
// spi master model on the link side of the control block
`timescale 1ns/10ps
module scr_spi_master (
  output logic sck,
  output logic ss_n,
  output logic mosi,
  input wire logic miso
);
  // ----
  // one frame, 80 ns link clock, stands still between frames
  // ----
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic xfer(input logic [7:0] t, input logic pol, input logic pha, input logic lsb,
    output logic [7:0] r);
    int b;
    // 3 ns after the rising bus clock edges, so no pin moves on a sampling edge
    #3 sck = pol;
    #200 ss_n = 1'b0;
    #200;
    for (int i = 0; i < 8; i++) begin
      b = lsb ? i : 7 - i;
      if (!pha) mosi = t[b];
      #40 sck = ~pol;
      if (pha) mosi = t[b]; else r[b] = miso;
      #40 sck = pol;
      if (pha) r[b] = miso;
    end
    #100 ss_n = 1'b1;
    mosi = ~mosi; // released line shows no stale bit
  endtask
endmodule // scr_spi_master

// ==== scr_spi_ctrl_tb.sv ====
// self-checking bench of the spi control block
`timescale 1ns/10ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module scr_spi_ctrl_tb;
  logic clk, sys_rst, psel, penable, pwrite, guard_wp, guard_secure, er;
  logic pready, pslverr, guard_err, irq, miso_o, miso_oe;
  logic [7:0] paddr, rx;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [2:0] pprot;
  wire sck, ss_n, mosi;
  wire miso = miso_oe ? miso_o : 1'bz;
  int num_errors, tests_run, cyc;
  typedef struct packed {logic [31:0] ctl; logic [7:0] dtx; logic [7:0] mtx;} scr_row_t;
  scr_row_t rows [4] = '{'{32'h0000_0000, 8'hA5, 8'h3C}, '{32'h5000_0000, 8'h81, 8'h7E},
    '{32'h2000_0000, 8'h01, 8'hC4}, '{32'h7000_0000, 8'hF0, 8'h96}};
  scr_spi_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .guard_wp(guard_wp), .guard_secure(guard_secure),
    .guard_err(guard_err), .irq(irq), .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso_o(miso_o),
    .miso_oe(miso_oe));
  scr_spi_master P (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso));
  // ----
  // clock, timeout, bus task
  // ----
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [2:0] p);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata, pstrb, pprot} <= {2'b10, w, a, d, s, p};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----
  // mode rows, then odd cases
  // ----
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, pstrb, pprot, guard_wp, guard_secure} = '0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    apb(0, 8'h00, 0, 4'hF, 0); `CHK("ctrl reset", 32'h0000_0000, rd)
    apb(1, 8'h16, 1, 4'h1, 0);
    foreach (rows[i]) begin
      apb(1, 8'h00, rows[i].ctl, 4'hF, 0);
      apb(0, 8'h00, 0, 4'hF, 0); `CHK("ctrl mode", rows[i].ctl, rd)
      apb(1, 8'h28, rows[i].dtx, 4'h1, 0);
      apb(1, 8'h00, 2, 4'h1, 0);
      P.xfer(rows[i].mtx, rows[i].ctl[29], rows[i].ctl[28], rows[i].ctl[30], rx);
      repeat (6) @(posedge clk);
      `CHK("rx master", rows[i].dtx, rx)
      `CHK("irq", 1'b1, irq)
      apb(0, 8'h28, 0, 4'hF, 2); `CHK("rx device", rows[i].mtx, rd[7:0])
      apb(0, 8'h18, 0, 4'hF, 2); `CHK("status", 32'h0000_0003, rd)
      apb(1, 8'h14, 7, 4'h1, 0);
      @(posedge clk);
      `CHK("irq clear", 1'b0, irq)
      apb(1, 8'h00, 0, 4'h1, 0); // enable bit writable while enabled
    end
    apb(1, 8'h00, 32'h0000_0002, 4'hF, 0);
    apb(1, 8'h00, 32'h4000_0002, 4'hF, 0);
    apb(0, 8'h00, 0, 4'hF, 0); `CHK("enable prot", 32'h0000_0002, rd)
    apb(1, 8'h00, 32'h0000_0001, 4'h1, 0);
    apb(0, 8'h00, 0, 4'hF, 0); `CHK("soft reset", 32'h0000_0000, rd)
    apb(1, 8'h00, 32'hFF00_0000, 4'h8, 0);
    apb(1, 8'h00, 32'h0000_0080, 4'h1, 0);
    apb(0, 8'h00, 0, 4'hF, 0); `CHK("lanes", 32'h7F00_0080, rd)
    guard_wp <= 1'b1;
    apb(1, 8'h00, 0, 4'hF, 0); `CHK("wp err", 1'b1, er)
    apb(0, 8'h00, 0, 4'hF, 0); `CHK("wp read", 32'h7F00_0080, rd)
    {guard_wp, guard_secure} <= 2'b01;
    apb(1, 8'h00, 0, 4'hF, 2); `CHK("ns err", 1'b1, er)
    apb(0, 8'h00, 0, 4'hF, 2); `CHK("ns read", 32'h0000_0000, rd)
    apb(0, 8'h00, 0, 4'hF, 0); `CHK("s read", 32'h7F00_0080, rd)
    guard_secure <= 1'b0;
    apb(0, 8'h00, 0, 4'hF, 2); `CHK("ns grant", 32'h7F00_0080, rd)
    apb(0, 8'h40, 0, 4'hF, 0); `CHK("unmapped", 1'b1, er)
    apb(0, 8'h18, 0, 4'hF, 0); `CHK("err flag", 1'b1, rd[2])
    `CHK("masked", 1'b0, irq)
    apb(1, 8'h16, 7, 4'h1, 0);
    @(posedge clk);
    `CHK("err irq", 1'b1, irq)
    // second reset in mid-run clears flags, enables and the control word
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    `CHK("irq in reset", 1'b0, irq)
    apb(0, 8'h00, 0, 4'hF, 0); `CHK("ctrl after reset", 32'h0000_0000, rd)
    apb(0, 8'h18, 0, 4'hF, 0); `CHK("status after reset", 32'h0000_0000, rd)
    tally_and_finish();
  end
endmodule // scr_spi_ctrl_tb
